/* bztg_defs.vh */
`ifndef BZTG_DEFS_VH
`define BZTG_DEFS_VH

// Clock and timebase rates in hertz.
`define BZTG_CLK_HZ 40000000
`define BZTG_BASE_HZ 65536
`define BZTG_SYNC_HZ 256
`define BZTG_US_PER_S 1000000

// Times in microseconds and their counts of 256 Hz sync ticks.
`define BZTG_ENV_FAST_US 62500
`define BZTG_ENV_SLOW_US 125000
`define BZTG_SHOT_SHORT_US 31250
`define BZTG_SHOT_LONG_US 62500
`define BZTG_ENV_FAST_TICKS ((`BZTG_ENV_FAST_US * `BZTG_SYNC_HZ) / `BZTG_US_PER_S)
`define BZTG_ENV_SLOW_TICKS ((`BZTG_ENV_SLOW_US * `BZTG_SYNC_HZ) / `BZTG_US_PER_S)
`define BZTG_SHOT_SHORT_TICKS ((`BZTG_SHOT_SHORT_US * `BZTG_SYNC_HZ) / `BZTG_US_PER_S)
`define BZTG_SHOT_LONG_TICKS ((`BZTG_SHOT_LONG_US * `BZTG_SYNC_HZ) / `BZTG_US_PER_S)

// Register indices; the byte address is four times the index.
`define BZTG_IDX_PIN_PORT 12'hF54
`define BZTG_IDX_TONE_SETUP 12'hF74
`define BZTG_IDX_ENV_CTRL 12'hF75
`define BZTG_ADDR_PIN_PORT {2'b00, `BZTG_IDX_PIN_PORT, 2'b00}
`define BZTG_ADDR_TONE_SETUP {2'b00, `BZTG_IDX_TONE_SETUP, 2'b00}
`define BZTG_ADDR_ENV_CTRL {2'b00, `BZTG_IDX_ENV_CTRL, 2'b00}

// Field positions.
`define BZTG_BIT_PIN_CTRL 3
`define BZTG_BIT_SECOND_PORT 2
`define BZTG_BIT_SHOT_LEN 3
`define BZTG_BIT_TRIGGER 3
`define BZTG_BIT_ENV_RESTART 2
`define BZTG_BIT_ENV_RATE 1
`define BZTG_BIT_ENV_ENABLE 0

// Reset values.
`define BZTG_PORT_RST 4'hF
`define BZTG_SETUP_RST 4'h0
`define BZTG_ENV_RST 1'b0

// Tone period and duty figures in tone unit ticks.
`define BZTG_PERIOD_BASE 5'h10
`define BZTG_HIGH_SHORT 4'h8
`define BZTG_HIGH_LONG 4'hC
`define BZTG_LEVEL_MIN 3'h7

`endif

/* bztg_rate_div.v */
`timescale 1ns/1ps
`default_nettype none

module bztg_rate_div #(
    parameter CLK_HZ = 40000000,
    parameter OUT_HZ = 65536
) (
    input wire ref_clk,
    input wire nrst,
    output wire tick
);

    // A phase accumulator keeps the average rate exact even though the
    // ratio of the two rates is not an integer; the cost is jitter of one
    // clock period on single ticks.
    reg [26:0] acc_ff;
    reg tick_ff;
    wire [27:0] sum = {1'b0, acc_ff} + OUT_HZ[27:0];
    wire [27:0] diff = sum - CLK_HZ[27:0];
    wire wrap = (sum >= CLK_HZ[27:0]);

    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            acc_ff <= 27'h0000000;
            tick_ff <= 1'b0;
        end
        else
        begin
            acc_ff <= wrap ? diff[26:0] : sum[26:0];
            tick_ff <= wrap;
        end
    end

    assign tick = tick_ff;

endmodule // bztg_rate_div

`default_nettype wire

/* bztg_top.v */
// Notes on behaviour
// [R01] Tone select picks one of eight frequencies.
// [R02] Tone select resets to zero, 4096 Hz.
// [R03] Restart write one returns duty to maximum.
// [R04] Restart ignored when envelope off or silent.
// [R05] Envelope enable applies decay, reset clear.
// [R06] Rate bit picks 125 ms or 62.5 ms.
// [R07] First step within 4 ms of nominal.
// [R08] Pin control zero outputs tone, one low.
// [R09] Second pin carries inverted tone, low off.
// [R10] Second port bit is plain storage then.
// [R11] Reset sets pin control and port bit.
// [R12] Shot length picks 62.5 or 31.25 ms.
// [R13] Trigger write one starts one-shot tone.
// [R14] Trigger ignored while regular tone is on.
// [R15] Trigger bit reads busy until shot ends.
// [R16] Shot starts and stops on 256 Hz tick.
// [R17] Envelope walks eight duty levels downward.
// [R18] Envelope off keeps duty at one half; code gives 8 of 20 and 12 of 28 units for select 1 and 3.
// [R19] Timing from integer division, duty by count.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "bztg_defs.vh"

module bztg_top (
    input wire ref_clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire secondPinInverted,
    output wire toneOut,
    output wire secondPinOut,
    output wire [1:0] portOut
);

    localparam ENV_FAST = `BZTG_ENV_FAST_TICKS;
    localparam ENV_SLOW = `BZTG_ENV_SLOW_TICKS;
    localparam SHOT_SHORT = `BZTG_SHOT_SHORT_TICKS;
    localparam SHOT_LONG = `BZTG_SHOT_LONG_TICKS;

    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg [3:0] port_ff;
    reg [3:0] setup_ff;
    reg envEnable_ff;
    reg envRate_ff;
    reg [2:0] envLevel_ff;
    reg [5:0] envCnt_ff;
    reg shotPending_ff;
    reg shotActive_ff;
    reg [4:0] shotCnt_ff;
    reg [7:0] pre_ff;
    reg [4:0] phase_ff;
    reg toneOut_ff;
    reg secondPinOut_ff;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    reg [2:0] nxt_envLevel;
    reg [5:0] nxt_envCnt;
    reg nxt_shotPending;
    reg nxt_shotActive;
    reg [4:0] nxt_shotCnt;
    reg [4:0] nxt_phase;

    wire baseTick;
    wire [2:0] toneSelect = setup_ff[2:0];
    wire oneshotLength = setup_ff[`BZTG_BIT_SHOT_LEN];
    wire pinControl = port_ff[`BZTG_BIT_PIN_CTRL];
    wire regularOn = ~pinControl;
    wire toneActive = regularOn | shotActive_ff;
    wire oneshotBusy = shotPending_ff | shotActive_ff;

    // Bus decode: a transfer completes at the edge where the registered
    // ready is seen together with select and enable.
    wire accessPhase = psel & penable;
    wire xferDone = accessPhase & pready_ff;
    wire wrDone = xferDone & pwrite;
    wire hitPort = (paddr == `BZTG_ADDR_PIN_PORT);
    wire hitSetup = (paddr == `BZTG_ADDR_TONE_SETUP);
    wire hitCtrl = (paddr == `BZTG_ADDR_ENV_CTRL);
    wire hitAny = hitPort | hitSetup | hitCtrl;

    // An unmapped word answers with an error and leaves all state alone.
    wire badAddr = ~hitAny;
    wire wrPort = wrDone & hitPort;
    wire wrSetup = wrDone & hitSetup;
    wire wrCtrl = wrDone & hitCtrl;

    // Write strobes for the self-clearing and trigger bits.
    wire restartReq = wrCtrl & pwdata[`BZTG_BIT_ENV_RESTART];
    wire restartOk = restartReq & envEnable_ff & toneActive; // [R04]
    wire triggerReq = wrCtrl & pwdata[`BZTG_BIT_TRIGGER];
    // The trigger is taken only while pin control reads one, the state in
    // which the regular tone is silent; busy triggers are dropped as well.
    wire triggerOk = triggerReq & pinControl & ~oneshotBusy; // [R14]
    wire envEnableNext = wrCtrl ? pwdata[`BZTG_BIT_ENV_ENABLE] : envEnable_ff;
    wire envStart = envEnableNext & ~envEnable_ff;

    // Timebase: the 65536 Hz base tick comes from an accumulator divider.
    bztg_rate_div #(
        .CLK_HZ(`BZTG_CLK_HZ),
        .OUT_HZ(`BZTG_BASE_HZ)
    ) u_base_div (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(baseTick)
    ); // [R19]

    // Sync tick at 256 Hz and the tone unit tick, which halves for the
    // four lower frequencies.
    wire syncTick = baseTick & (pre_ff == 8'hFF); // [R16]
    wire unitTick = baseTick & (~toneSelect[2] | pre_ff[0]); // [R01]

    // Tone period 16, 20, 24 or 28 units; duty high time from the level.
    wire [4:0] period = `BZTG_PERIOD_BASE + {1'b0, toneSelect[1:0], 2'b00}; // [R01]
    wire [3:0] highMax = toneSelect[1] ? `BZTG_HIGH_LONG : `BZTG_HIGH_SHORT;
    wire [3:0] highTime = highMax - {1'b0, envLevel_ff}; // [R17]
    wire toneHigh = (phase_ff < {1'b0, highTime}); // [R19]

    // Envelope step length in sync ticks and one-shot length in sync ticks.
    wire [5:0] envTarget = envRate_ff ? ENV_SLOW[5:0] : ENV_FAST[5:0]; // [R06]
    wire [4:0] shotTarget = oneshotLength ? SHOT_LONG[4:0] : SHOT_SHORT[4:0]; // [R12]

    // Prescaler of base ticks; shared by the sync tick and the tone unit.
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            pre_ff <= 8'h00;
        end
        else if (baseTick)
        begin
            pre_ff <= pre_ff + 8'h01;
        end
    end

    // Software-written control fields.
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            port_ff <= `BZTG_PORT_RST; // [R11]
            setup_ff <= `BZTG_SETUP_RST; // [R02]
            envEnable_ff <= `BZTG_ENV_RST; // [R05]
            envRate_ff <= `BZTG_ENV_RST; // [R06]
        end
        else
        begin
            if (wrPort)
            begin
                port_ff <= pwdata[3:0]; // [R10]
            end
            if (wrSetup)
            begin
                setup_ff <= pwdata[3:0]; // [R01]
            end
            if (wrCtrl)
            begin
                envEnable_ff <= pwdata[`BZTG_BIT_ENV_ENABLE]; // [R05]
                envRate_ff <= pwdata[`BZTG_BIT_ENV_RATE]; // [R06]
            end
        end
    end

    // Envelope: the step counter restarts when the envelope is switched on,
    // so the first step lands one sync tick early at most, under 4 ms.
    always @*
    begin
        nxt_envLevel = envLevel_ff;
        nxt_envCnt = envCnt_ff;
        if (!envEnableNext)
        begin
            nxt_envLevel = 3'h0; // [R18]
            nxt_envCnt = 6'h00;
        end
        else if (envStart || restartOk)
        begin
            nxt_envLevel = 3'h0; // [R03]
            nxt_envCnt = 6'h00; // [R07]
        end
        else if (syncTick)
        begin
            if (envCnt_ff + 6'h01 >= envTarget)
            begin
                nxt_envCnt = 6'h00;
                if (envLevel_ff != `BZTG_LEVEL_MIN)
                begin
                    nxt_envLevel = envLevel_ff + 3'h1; // [R17]
                end
            end
            else
            begin
                nxt_envCnt = envCnt_ff + 6'h01; // [R06]
            end
        end
    end

    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            envLevel_ff <= 3'h0;
            envCnt_ff <= 6'h00;
        end
        else
        begin
            envLevel_ff <= nxt_envLevel;
            envCnt_ff <= nxt_envCnt;
        end
    end

    // One-shot: a taken trigger waits for the next sync tick, then the
    // tone runs for a whole number of sync ticks and stops on one.
    always @*
    begin
        nxt_shotPending = shotPending_ff;
        nxt_shotActive = shotActive_ff;
        nxt_shotCnt = shotCnt_ff;
        if (triggerOk)
        begin
            nxt_shotPending = 1'b1; // [R13]
        end
        else if (syncTick && shotPending_ff)
        begin
            nxt_shotPending = 1'b0;
            nxt_shotActive = 1'b1; // [R16]
            nxt_shotCnt = 5'h00;
        end
        else if (syncTick && shotActive_ff)
        begin
            if (shotCnt_ff + 5'h01 >= shotTarget)
            begin
                nxt_shotActive = 1'b0; // [R16]
                nxt_shotCnt = 5'h00;
            end
            else
            begin
                nxt_shotCnt = shotCnt_ff + 5'h01; // [R12]
            end
        end
    end

    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            shotPending_ff <= 1'b0; // [R15]
            shotActive_ff <= 1'b0;
            shotCnt_ff <= 5'h00;
        end
        else
        begin
            shotPending_ff <= nxt_shotPending;
            shotActive_ff <= nxt_shotActive;
            shotCnt_ff <= nxt_shotCnt;
        end
    end

    // Tone phase counter; held at zero while silent so every burst starts
    // with a full high time. Frequency changes mid-tone may glitch one cycle.
    always @*
    begin
        nxt_phase = phase_ff;
        if (!toneActive)
        begin
            nxt_phase = 5'h00;
        end
        else if (unitTick)
        begin
            if (phase_ff + 5'h01 >= period)
            begin
                nxt_phase = 5'h00; // [R01]
            end
            else
            begin
                nxt_phase = phase_ff + 5'h01;
            end
        end
    end

    // Pin drivers: with the second pin inverted, both follow the same phase so they switch together.
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            phase_ff <= 5'h00;
            toneOut_ff <= 1'b0;
            secondPinOut_ff <= 1'b0;
        end
        else
        begin
            phase_ff <= nxt_phase;
            toneOut_ff <= toneActive & toneHigh; // [R08]
            if (secondPinInverted)
            begin
                secondPinOut_ff <= toneActive & ~toneHigh; // [R09]
            end
            else
            begin
                secondPinOut_ff <= port_ff[`BZTG_BIT_SECOND_PORT];
            end
        end
    end

    // Read mux; the restart bit always reads zero and the trigger bit
    // reads the busy state.
    always @*
    begin
        nxt_prdata = 32'h00000000;
        nxt_pslverr = badAddr;
        if (hitPort)
        begin
            nxt_prdata = {28'h0000000, port_ff}; // [R10]
        end
        else if (hitSetup)
        begin
            nxt_prdata = {28'h0000000, setup_ff};
        end
        else if (hitCtrl)
        begin
            nxt_prdata = {28'h0000000, oneshotBusy, 1'b0, envRate_ff, envEnable_ff}; // [R15]
        end
        else
        begin
            nxt_pslverr = 1'b1;
        end
    end

    // One wait state: ready rises in the first access cycle and the
    // transfer completes on the second, which keeps every bus output
    // registered at the cost of one cycle per access.
    always @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= accessPhase & ~pready_ff;
            if (accessPhase && !pready_ff)
            begin
                pslverr_ff <= nxt_pslverr;
                prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
            end
            else
            begin
                pslverr_ff <= 1'b0;
                prdata_ff <= 32'h00000000;
            end
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign toneOut = toneOut_ff;
    assign secondPinOut = secondPinOut_ff;
    assign portOut = port_ff[1:0];

endmodule // bztg_top

`default_nettype wire

/* bztg_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bztg_defs.vh"

module bztg_top_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic secondPinInverted,
    input wire logic toneOut,
    input wire logic secondPinOut,
    input wire logic [1:0] portOut
);
    logic [3:0] setupShadow_ff;
    logic setupWrite;
    logic mapped;

    // Decode of completed setup writes and of the three mapped words.
    assign setupWrite = psel && penable && pready && pwrite && (paddr == `BZTG_ADDR_TONE_SETUP);
    assign mapped = (paddr == `BZTG_ADDR_PIN_PORT) || (paddr == `BZTG_ADDR_TONE_SETUP)
        || (paddr == `BZTG_ADDR_ENV_CTRL);

    // Shadow of the setup word, so every read of it can be judged.
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            setupShadow_ff <= 4'h0;
        else if (setupWrite)
            setupShadow_ff <= pwdata[3:0];
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_unmapped: assert property (pready |-> (pslverr == !mapped))
        else $error("pslverr does not match the address map");
    a_rdata_upper: assert property (pready |-> prdata[31:4] == 28'h0000000)
        else $error("upper read data bits not zero");
    a_restart_zero: assert property (
        pready && !pwrite && paddr == `BZTG_ADDR_ENV_CTRL |-> !prdata[2])
        else $error("restart bit read back as one");
    a_setup_readback: assert property (
        pready && !pwrite && paddr == `BZTG_ADDR_TONE_SETUP |-> prdata[3:0] == setupShadow_ff)
        else $error("setup word read back wrong");
    a_inverse_pin: assert property (
        secondPinInverted && $past(secondPinInverted) && toneOut |-> !secondPinOut)
        else $error("second pin not inverse of tone");
    a_reset_off: assert property (disable iff (1'b0) !nrst |=> !toneOut && portOut == 2'h3)
        else $error("tone or port bits wrong under reset");
endmodule // bztg_top_sva

bind bztg_top bztg_top_sva chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .secondPinInverted(secondPinInverted), .toneOut(toneOut),
    .secondPinOut(secondPinOut), .portOut(portOut));
`default_nettype wire

/* bztg_buzzer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bztg_buzzer_model (
    input wire logic toneOut,
    output var real lastPeriod,
    output var real lastHigh,
    output var int riseCount
);
    real riseAt;

    // A buzzer reacts only to edges, so time stamps give period and pulse width.
    initial
    begin
        riseAt = 0.0;
        lastPeriod = 0.0;
        lastHigh = 0.0;
        riseCount = 0;
        forever
        begin
            @(posedge toneOut);
            lastPeriod = $realtime - riseAt;
            riseAt = $realtime;
            riseCount++;
            @(negedge toneOut);
            lastHigh = $realtime - riseAt;
        end
    end
endmodule // bztg_buzzer_model
`default_nettype wire

/* bztg_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bztg_defs.vh"

module bztg_top_bench;
    localparam logic [15:0] A_PIN = `BZTG_ADDR_PIN_PORT;
    localparam logic [15:0] A_SET = `BZTG_ADDR_TONE_SETUP;
    localparam logic [15:0] A_ENV = `BZTG_ADDR_ENV_CTRL;
    logic ref_clk, nrst, psel, penable, pwrite, secondPinInverted, rdErr;
    logic [15:0] paddr;
    logic [31:0] pwdata, rdData, hi;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, toneOut, secondPinOut;
    wire logic [1:0] portOut;
    real lastPeriod, lastHigh;
    int riseCount, err_total, n_tests;

    bztg_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .secondPinInverted(secondPinInverted), .toneOut(toneOut),
        .secondPinOut(secondPinOut), .portOut(portOut));
    bztg_buzzer_model buzzer (.toneOut(toneOut), .lastPeriod(lastPeriod),
        .lastHigh(lastHigh), .riseCount(riseCount));

    // Clock of 25 ns.
    initial
        ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task results;
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task apb(input logic [15:0] addr, input logic wr, input logic [31:0] data);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check({31'h0, pready}, 32'h1);
    endtask

    task wr(input logic [15:0] addr, input logic [3:0] v);
        apb(addr, 1'b1, {28'h0, v});
    endtask

    task rdChk(input logic [15:0] addr, input logic [3:0] exp);
        apb(addr, 1'b0, 32'h0);
        check(rdData, {28'h0, exp});
    endtask

    // Period and high time in ns; 60 ns covers the divider's one-cycle jitter.
    task toneChk(input logic [2:0] code);
        int start, n;
        real base, perExp, highExp;
        wr(A_SET, {1'b0, code});
        base = code[2] ? 32768.0 : 65536.0;
        perExp = (16 + 4 * code[1:0]) * 1.0e9 / base;
        highExp = (code[1] ? 12 : 8) * 1.0e9 / base;
        start = riseCount;
        n = 0;
        while (riseCount < start + 2 && n < 45000)
        begin
            @(posedge ref_clk);
            n++;
        end
        n_tests++;
        if (n >= 45000 || lastPeriod < perExp - 60.0 || lastPeriod > perExp + 60.0
            || lastHigh < highExp - 60.0 || lastHigh > highExp + 60.0)
        begin
            err_total++;
            $display("unexpected tone at %0t: got %h/%h, expected %h/%h", $time,
                $rtoi(lastPeriod), $rtoi(lastHigh), $rtoi(perExp), $rtoi(highExp));
        end
    endtask

    // The tests take about 90k cycles; this cuts a hang at twice that.
    initial
    begin
        #5000000;
        err_total++;
        results;
    end

    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        secondPinInverted = 1'b1;
        err_total = 0;
        n_tests = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        rdChk(A_PIN, 4'hF);
        rdChk(A_SET, 4'h0);
        rdChk(A_ENV, 4'h0);
        apb(16'h0010, 1'b0, 32'h0);
        check({31'h0, rdErr}, 32'h1);
        check(rdData, 32'h0);
        // Regular tone on; a trigger now must be dropped.
        wr(A_PIN, 4'h7);
        wr(A_ENV, 4'h8);
        rdChk(A_ENV, 4'h0);
        toneChk(3'h4);
        toneChk(3'h1);
        toneChk(3'h0);
        // Tone off: both pins must sit low for longer than a period.
        wr(A_PIN, 4'h8);
        repeat (3) @(posedge ref_clk);
        hi = 0;
        repeat (10000)
        begin
            @(posedge ref_clk);
            if (toneOut !== 1'b0 || secondPinOut !== 1'b0)
                hi++;
        end
        check(hi, 32'h0);
        rdChk(A_PIN, 4'h8);
        check({30'h0, portOut}, 32'h0);
        @(posedge ref_clk);
        secondPinInverted <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, secondPinOut}, 32'h0);
        wr(A_PIN, 4'hF);
        repeat (3) @(posedge ref_clk);
        check({31'h0, secondPinOut}, 32'h1);
        check({30'h0, portOut}, 32'h3);
        secondPinInverted <= 1'b1;
        wr(A_ENV, 4'h7);
        rdChk(A_ENV, 4'h3);
        wr(A_SET, 4'hD);
        rdChk(A_SET, 4'hD);
        // Tone is off now, so the trigger is taken and reads busy.
        wr(A_ENV, 4'hB);
        rdChk(A_ENV, 4'hB);
        results;
    end
endmodule // bztg_top_bench
`default_nettype wire
